//--- common/tuid_pkg.sv
// package: register map, field layouts and fixed values of the trace unit id/config bank
// assumes: a 32-bit apb slave with byte addresses and one aligned word per register
package tuid_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CAPABILITY  = 12'h004;
  localparam logic [11:0] OFS_OUT_CONTROL = 12'h00C;
  localparam logic [11:0] OFS_IDENTITY    = 12'h1E4;
  localparam logic [11:0] OFS_CAP_EXT     = 12'h1E8;
  localparam logic [11:0] OFS_IN_SELECT   = 12'h1EC;
  localparam logic [11:0] OFS_POWER_STAT  = 12'h314;
  localparam logic [11:0] OFS_PID4        = 12'hFD0;
  localparam logic [11:0] OFS_PID5        = 12'hFD4;
  localparam logic [11:0] OFS_PID6        = 12'hFD8;
  localparam logic [11:0] OFS_PID7        = 12'hFDC;
  localparam logic [11:0] OFS_PID0        = 12'hFE0;
  localparam logic [11:0] OFS_PID1        = 12'hFE4;
  localparam logic [11:0] OFS_PID2        = 12'hFE8;
  localparam logic [11:0] OFS_PID3        = 12'hFEC;

  // capability word fixed part and field positions
  localparam logic [31:0] CAP_FIXED       = 32'h8D014024;
  localparam int          CAP_EXTOUT_LSB  = 20;
  localparam int          CAP_EXTIN_LSB   = 17;
  localparam logic [1:0]  EXTOUT_MAX      = 2'h2;
  localparam logic [2:0]  EXTIN_MAX       = 3'h4;

  // identity word fields
  localparam logic [7:0]  ID_MAKER        = 8'h5A; // arbitrary value
  localparam logic [3:0]  ID_REVISION     = 4'h6; // arbitrary value
  localparam logic [3:0]  ID_FAMILY       = 4'hF;
  localparam logic [3:0]  ID_MAJOR        = 4'h2;
  localparam logic [3:0]  ID_MINOR        = 4'h3;
  localparam logic [3:0]  ID_FLAGS        = 4'h4; // bit18 set, 19/17/16 clear

  // extended capability and power status
  localparam logic [31:0] CAP_EXT_VALUE   = 32'h0000097A;
  localparam logic [31:0] POWER_VALUE     = 32'h00000001;
  localparam logic [31:0] IN_SELECT_MASK  = 32'h00003F3F;
  localparam logic [31:0] IN_SELECT_RESET = 32'h00000000;
  localparam logic [31:0] RDATA_RESET     = 32'h00000000;

  // peripheral id designer and part codes, arbitrary values
  localparam logic [3:0]  PID_CONTINUE    = 4'h2; // arbitrary value
  localparam logic [6:0]  PID_DESIGNER    = 7'h25; // arbitrary value
  localparam logic [11:0] PID_PART        = 12'h123; // arbitrary value
  localparam logic [3:0]  PID_SIZE        = 4'h0;
  localparam logic        PID_JEDEC       = 1'b1;

endpackage : tuid_pkg

//--- rtl/tuid_regs.sv
// file: id and capability register bank of the trace unit, apb slave
// assumes: apb3 master on clk; tie-offs static; no wait states inserted
`timescale 1ns/1ps
module tuid_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // tie-offs
  input  wire logic [1:0]  max_ext_output_tieoff,
  input  wire logic [2:0]  max_ext_input_tieoff,
  // general outputs
  output logic      [7:0]  general_output_bus
);

  // timing: a read is decoded in the setup cycle and its word is loaded into
  // rdata_q at the edge that starts the access cycle, so prdata leaves a flop
  // and stands for the whole access cycle; pready is tied high, so a transfer
  // is one setup cycle plus one access cycle.
  // writes take effect at the edge that ends the access cycle.
  // a read right after a write to the same word sees the new value, because
  // the write lands before the edge at which the read word is loaded.
  // the error flag is loaded at the same edge as the read word, for reads and
  // writes alike, so prdata comes from a flop and pslverr from a flop gated by the access phase.

  // register map, byte offsets, one aligned word each:
  //   0x004 capability word, read only, tie-off counts merged in
  //   0x00C general output control, low byte read/write, no reset
  //   0x1E4 identity word, read only
  //   0x1E8 extended capability word, read-only constant
  //   0x1EC extended input selector, two six-bit fields
  //   0x314 power state status, read-only constant
  //   0xFD0 peripheral id byte 4
  //   0xFD4 peripheral id byte 5
  //   0xFD8 peripheral id byte 6
  //   0xFDC peripheral id byte 7
  //   0xFE0 peripheral id byte 0
  //   0xFE4 peripheral id byte 1
  //   0xFE8 peripheral id byte 2
  //   0xFEC peripheral id byte 3
  // anything else answers with pslverr; writes to read-only words are dropped

  // software-visible storage; the output control byte has no reset on purpose
  logic [7:0]  general_output_control;
  logic [31:0] extended_input_selector;

  // bus phase decode
  logic        setup_phase;
  logic        access_phase;
  logic        setup_read;
  logic        wr_en;

  // one select per read source; at most one is high for any address
  logic        sel_capability;
  logic        sel_out_control;
  logic        sel_identity;
  logic        sel_cap_ext;
  logic        sel_in_select;
  logic        sel_power;
  logic        sel_pid;
  logic        addr_mapped;

  // value each source would return if selected
  logic [31:0] capability_word;
  logic [31:0] out_control_word;
  logic [31:0] identity_word;
  logic [31:0] cap_ext_word;
  logic [31:0] in_select_word;
  logic [31:0] power_word;
  logic [31:0] pid_high_word;
  logic [31:0] pid_low_word;

  // read path: combinational select, then one register stage
  logic [31:0] next_rdata;
  logic [31:0] rdata_q;
  logic        err_q;

  // clamp of the external-output tie-off
  // counts above the supported maximum are never reported
  function automatic logic [1:0] clamp_ext_out(input logic [1:0] tie);
    logic [1:0] cnt;
    if (tie > tuid_pkg::EXTOUT_MAX) begin
      cnt = tuid_pkg::EXTOUT_MAX;
    end else begin
      cnt = tie;
    end
    return cnt;
  endfunction : clamp_ext_out

  // clamp of the external-input tie-off
  // counts above the supported maximum are never reported
  function automatic logic [2:0] clamp_ext_in(input logic [2:0] tie);
    logic [2:0] cnt;
    if (tie > tuid_pkg::EXTIN_MAX) begin
      cnt = tuid_pkg::EXTIN_MAX;
    end else begin
      cnt = tie;
    end
    return cnt;
  endfunction : clamp_ext_in

  // capability word: fixed flags with the two clamped counts merged in
  // fixed part: identity present, software access, start/stop, one context
  // comparator, no stall, sequencer, two counters, two data cmp, four pairs
  // bit 22 stays clear because the clamped output count fits in two bits
  function automatic logic [31:0] capability_value(input logic [1:0] tie_out,
                                                   input logic [2:0] tie_in);
    logic [31:0] word;
    logic [31:0] out_cnt;
    logic [31:0] in_cnt;
    out_cnt = {30'h00000000, clamp_ext_out(tie_out)};
    in_cnt  = {29'h00000000, clamp_ext_in(tie_in)};
    word    = tuid_pkg::CAP_FIXED;
    word    = word | (out_cnt << tuid_pkg::CAP_EXTOUT_LSB);
    word    = word | (in_cnt << tuid_pkg::CAP_EXTIN_LSB);
    return word;
  endfunction : capability_value

  // identity word: maker byte, flag nibble, family and versions, revision
  // the revision nibble is shared with peripheral id byte 2
  function automatic logic [31:0] identity_value();
    logic [31:0] word;
    word = {tuid_pkg::ID_MAKER,      // maker byte
            4'h0,                    // reserved nibble
            tuid_pkg::ID_FLAGS,
            tuid_pkg::ID_FAMILY,
            tuid_pkg::ID_MAJOR,
            tuid_pkg::ID_MINOR,
            tuid_pkg::ID_REVISION};
    return word;
  endfunction : identity_value

  // id byte packing: low byte used, upper bits zero
  // zero rather than undefined keeps every read deterministic
  function automatic logic [31:0] id_byte(input logic [7:0] b);
    return {24'h000000, b};
  endfunction : id_byte

  // peripheral id bytes 4 to 7, which sit below bytes 0 to 3 in the map
  // a miss returns zero so the word can be merged with the low half
  function automatic logic [31:0] pid_high_value(input logic [11:0] addr);
    logic [31:0] word;
    word = 32'h00000000;
    unique case (addr)
      tuid_pkg::OFS_PID4: begin
        word = id_byte({tuid_pkg::PID_SIZE,
                        tuid_pkg::PID_CONTINUE});
      end
      tuid_pkg::OFS_PID5: begin
        word = id_byte(8'h00);
      end
      tuid_pkg::OFS_PID6: begin
        word = id_byte(8'h00);
      end
      tuid_pkg::OFS_PID7: begin
        word = id_byte(8'h00);
      end
      default: begin
        word = 32'h00000000;
      end
    endcase
    return word;
  endfunction : pid_high_value

  // peripheral id bytes 0 to 3; byte 2 repeats the identity revision nibble
  // a miss returns zero so the word can be merged with the high half
  function automatic logic [31:0] pid_low_value(input logic [11:0] addr);
    logic [31:0] word;
    word = 32'h00000000;
    unique case (addr)
      tuid_pkg::OFS_PID0: begin
        word = id_byte(tuid_pkg::PID_PART[7:0]);
      end
      tuid_pkg::OFS_PID1: begin
        word = id_byte({tuid_pkg::PID_DESIGNER[3:0],
                        tuid_pkg::PID_PART[11:8]});
      end
      tuid_pkg::OFS_PID2: begin
        word = id_byte({tuid_pkg::ID_REVISION, tuid_pkg::PID_JEDEC,
                        tuid_pkg::PID_DESIGNER[6:4]});
      end
      tuid_pkg::OFS_PID3: begin
        word = id_byte(8'h00);
      end
      default: begin
        word = 32'h00000000;
      end
    endcase
    return word;
  endfunction : pid_low_value

  // any of the eight peripheral id offsets
  // misaligned addresses fall to the default and count as unmapped
  function automatic logic is_pid(input logic [11:0] addr);
    logic hit;
    unique case (addr)
      tuid_pkg::OFS_PID4,
      tuid_pkg::OFS_PID5,
      tuid_pkg::OFS_PID6,
      tuid_pkg::OFS_PID7,
      tuid_pkg::OFS_PID0,
      tuid_pkg::OFS_PID1,
      tuid_pkg::OFS_PID2,
      tuid_pkg::OFS_PID3: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : is_pid

  // output control as read back
  // reserved bits read zero whatever software wrote there
  function automatic logic [31:0] out_control_read(input logic [7:0] ctl);
    return {24'h000000, ctl};
  endfunction : out_control_read

  // selector write value
  // reserved bits are dropped so readback stays deterministic
  function automatic logic [31:0] in_select_write(input logic [31:0] d);
    return d & tuid_pkg::IN_SELECT_MASK;
  endfunction : in_select_write

  // bus phases; setup is psel without penable
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;

  // write strobe for the access cycle, read capture in the setup cycle
  assign wr_en      = access_phase && pwrite;
  assign setup_read = setup_phase && !pwrite;

  // per-source address decode
  assign sel_capability  = (paddr == tuid_pkg::OFS_CAPABILITY);
  assign sel_out_control = (paddr == tuid_pkg::OFS_OUT_CONTROL);
  assign sel_identity    = (paddr == tuid_pkg::OFS_IDENTITY);
  assign sel_cap_ext     = (paddr == tuid_pkg::OFS_CAP_EXT);
  assign sel_in_select   = (paddr == tuid_pkg::OFS_IN_SELECT);
  assign sel_power       = (paddr == tuid_pkg::OFS_POWER_STAT);
  assign sel_pid         = is_pid(paddr);

  // an address is mapped when any source claims it
  assign addr_mapped = sel_capability
                    || sel_out_control
                    || sel_identity
                    || sel_cap_ext
                    || sel_in_select
                    || sel_power
                    || sel_pid;

  // zero-wait slave: every access completes in its first access cycle
  // the master still waits on pready, so a later wait state stays compatible
  assign pready = 1'b1;

  // output control: no reset, contents arbitrary until first write
  // software must write it before relying on the general output bus
  always_ff @(posedge clk) begin
    if (wr_en && sel_out_control) begin
      general_output_control <= pwdata[7:0];
    end
  end

  // bus driven straight from the register, no extra stage
  assign general_output_bus = general_output_control;

  // input selector; only a write to its own offset changes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      extended_input_selector <= tuid_pkg::IN_SELECT_RESET;
    end else if (wr_en && sel_in_select) begin
      extended_input_selector <= in_select_write(pwdata);
    end
  end

  // capability word; tie-offs are static so it is recomputed freely
  assign capability_word  = capability_value(max_ext_output_tieoff,
                                             max_ext_input_tieoff);
  // output control word with its reserved bits cleared
  assign out_control_word = out_control_read(general_output_control);
  // identity word, a constant
  assign identity_word    = identity_value();
  // extended capability word, a constant
  assign cap_ext_word     = tuid_pkg::CAP_EXT_VALUE;
  // selector word, already masked on write
  assign in_select_word   = extended_input_selector;
  // power state: always powered up, no sticky state
  assign power_word       = tuid_pkg::POWER_VALUE;
  // peripheral id halves; each is zero outside its own offsets
  assign pid_high_word    = pid_high_value(paddr);
  assign pid_low_word     = pid_low_value(paddr);

  // read mux; selects are one-hot so the order of the ifs implies no priority
  // an unmapped address leaves the word at zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (sel_capability) begin
      next_rdata = capability_word;
    end

    if (sel_out_control) begin
      next_rdata = out_control_word;
    end

    if (sel_identity) begin
      next_rdata = identity_word;
    end

    if (sel_cap_ext) begin
      next_rdata = cap_ext_word;
    end

    if (sel_in_select) begin
      next_rdata = in_select_word;
    end

    if (sel_power) begin
      next_rdata = power_word;
    end

    if (sel_pid) begin
      next_rdata = pid_high_word | pid_low_word;
    end
  end

  // read register: loaded in the setup cycle, held through the access cycle,
  // cleared when the bus is idle or a write is under way
  // loading one cycle early keeps prdata a flop output without a wait state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= tuid_pkg::RDATA_RESET;
    end else if (setup_read && addr_mapped) begin
      rdata_q <= next_rdata;
    end else if (!access_phase) begin
      rdata_q <= tuid_pkg::RDATA_RESET;
    end
  end

  // error register: loaded in the setup cycle for reads and writes alike,
  // so an unmapped access is flagged for its whole access cycle
  // it is gated by the access phase on the way out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if (setup_phase) begin
      err_q <= !addr_mapped;
    end else if (!access_phase) begin
      err_q <= 1'b0;
    end
  end

  // answers of the access cycle
  assign prdata  = rdata_q;
  assign pslverr = err_q && access_phase;

endmodule : tuid_regs

//--- bench/tuid_regs_assertions.sv
// checker: read values and write effects of the id/config bank
// assumes: bound onto tuid_regs; one clock, async active-high reset
`timescale 1ns/1ps
module tuid_regs_assertions (
  // clock, reset and apb
  input wire logic        clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // tie-offs and general outputs
  input wire logic [1:0]  max_ext_output_tieoff,
  input wire logic [2:0]  max_ext_input_tieoff,
  input wire logic [7:0]  general_output_bus
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // read access phase, shared by the read-value checks
  logic rd;
  assign rd = psel && penable && !pwrite;
  property p_cap; rd && paddr == 12'h004 |-> (prdata & 32'hFFC1FFFF) == 32'h8D014024; endproperty
  a_cap: assert property (p_cap) else $error("capability fixed part wrong");
  property p_out; rd && paddr == 12'h004 |-> prdata[21:20] ==
    (max_ext_output_tieoff > 2'h2 ? 2'h2 : max_ext_output_tieoff); endproperty
  a_out: assert property (p_out) else $error("output count wrong");
  property p_in; rd && paddr == 12'h004 |-> prdata[19:17] ==
    (max_ext_input_tieoff > 3'h4 ? 3'h4 : max_ext_input_tieoff); endproperty
  a_in: assert property (p_in) else $error("input count wrong");
  property p_ext; rd && paddr == 12'h1E8 |-> prdata == 32'h0000097A; endproperty
  a_ext: assert property (p_ext) else $error("extended capability wrong");
  property p_pwr; rd && paddr == 12'h314 |-> prdata == 32'h00000001; endproperty
  a_pwr: assert property (p_pwr) else $error("power status wrong");
  property p_id; rd && paddr == 12'h1E4 |-> prdata[23:4] == 20'h04F23; endproperty
  a_id: assert property (p_id) else $error("identity fields wrong");
  // id bytes 3, 5, 6 and 7 read zero whole
  property p_zero; rd && (paddr == 12'hFEC || paddr[11:4] == 8'hFD && paddr[3:2] != 2'h0)
    |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("zero id byte wrong");
  property p_bus; psel && penable && pwrite && paddr == 12'h00C
    |=> general_output_bus == $past(pwdata[7:0]); endproperty
  a_bus: assert property (p_bus) else $error("output bus not written");
endmodule : tuid_regs_assertions

bind tuid_regs tuid_regs_assertions tuid_regs_assertions_i (.clk, .rst, .psel, .penable,
  .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .max_ext_output_tieoff,
  .max_ext_input_tieoff, .general_output_bus);

//--- bench/tb.sv
// testbench: random and corner apb traffic on the id/config bank
// assumes: tuid_regs answers every access; tie-offs change only between transfers
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module tb;
  // clock, reset, apb and block pins
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic [1:0]  max_ext_output_tieoff = 0;
  logic [2:0]  max_ext_input_tieoff = 0;
  logic [7:0]  general_output_bus;
  int          mismatches = 0, num_checks = 0, seed;
  // read-only places and the value each must show; last one is unmapped
  logic [11:0] ofs [12] = '{12'h1E4, 12'h1E8, 12'h314, 12'hFD0, 12'hFD4, 12'hFD8, 12'hFDC,
    12'hFE0, 12'hFE4, 12'hFE8, 12'hFEC, 12'h008};
  logic [31:0] ex [12] = '{{tuid_pkg::ID_MAKER, 12'h04F, 8'h23, tuid_pkg::ID_REVISION},
    32'h0000097A, 32'h1, {28'h0, tuid_pkg::PID_CONTINUE}, 0, 0, 0,
    {24'h0, tuid_pkg::PID_PART[7:0]}, {24'h0, tuid_pkg::PID_DESIGNER[3:0],
    tuid_pkg::PID_PART[11:8]}, {24'h0, tuid_pkg::ID_REVISION, 1'b1,
    tuid_pkg::PID_DESIGNER[6:4]}, 0, 0};
  always #5 clk = ~clk;
  tuid_regs tuid_regs_i (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .max_ext_output_tieoff, .max_ext_input_tieoff, .general_output_bus);
  function automatic logic [31:0] cap_exp(logic [1:0] o, logic [2:0] i);
    return 32'h8D014024 | {(o > 2'h2 ? 2'h2 : o), 20'h0} | {(i > 3'h4 ? 3'h4 : i), 17'h0};
  endfunction : cap_exp
  task automatic results;
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // one transfer; request stays up so the next setup may follow at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin mismatches++; results(); end
    rd = prdata;
    err = pslverr;
  endtask : apb
  initial begin
    seed = $urandom(84);
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, 12'h004, 0);
    `CHK("cap_low", 32'h8D014024, rd)
    apb(0, 12'h1EC, 0);
    `CHK("sel_reset", 32'h0, rd)
    apb(1, 12'h314, 32'hFFFFFFFF); // writes to read-only places are dropped
    for (int k = 0; k < 32; k++) begin
      max_ext_output_tieoff <= k[4:3];
      max_ext_input_tieoff <= k[2:0];
      apb(0, 12'h004, 0);
      `CHK("cap", cap_exp(k[4:3], k[2:0]), rd)
    end
    for (int k = 0; k < 12; k++) begin
      apb(0, ofs[k], 0);
      `CHK("const", ex[k], rd)
      `CHK("slverr", k == 11, err)
    end
    repeat (20) begin
      v = $urandom;
      apb(1, 12'h00C, v);
      apb(0, 12'h00C, 0);
      `CHK("out_rd", {24'h0, v[7:0]}, rd)
      `CHK("out_bus", v[7:0], general_output_bus)
      apb(1, 12'h1EC, v);
      apb(0, 12'h1EC, 0);
      `CHK("sel", v & 32'h00003F3F, rd)
    end
    results();
  end
endmodule : tb
